// ---- src/kbd_code_break_gen.sv ----
/*
  Keyboard code and break generator top: selects a code source, shifts
  the eight pulses onto the send line, times breaks, and conditions the
  receive line onto the selector output. AXI4-Lite register slave.
  Assumes all inputs synchronous to mclk_i; a modem outside keys tones.
*/
`timescale 1ns/10ps
module kbd_code_break_gen
  import kbd_code_pkg::*;
#(
  parameter int unsigned DETECT_CYC  = BRK_DETECT_CYC,
  parameter int unsigned SPACE_A_CYC = BRK_SPACE_A_CYC,
  parameter int unsigned SPACE_B_CYC = BRK_SPACE_B_CYC,
  parameter int unsigned BIT_CYC     = PULSE_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  // character sources
  input  wire kbd_code_pkg::key_in_t key_i,
  input  wire logic                  key_strobe_i,
  input  wire logic [7:0]            tape_holes_i,
  input  wire logic                  tape_strobe_i,
  input  wire logic [7:0]            answer_drum_i,
  input  wire logic                  answer_strobe_i,
  output logic                       char_ready_o,
  // break and line control
  input  wire logic                  break_key_i,
  input  wire logic                  break_release_button_i,
  input  wire logic                  rx_break_detected_i,
  input  wire logic                  line_connected_i,
  input  wire logic                  copy_enable_i,
  input  wire logic                  rx_demod_i,
  output logic                       send_line_o,
  output logic                       selector_on_o,
  // AXI4-Lite slave
  input  wire logic [31:0]           s_awaddr_i,
  input  wire logic                  s_awvalid_i,
  output logic                       s_awready_o,
  input  wire logic [31:0]           s_wdata_i,
  input  wire logic [3:0]            s_wstrb_i,
  input  wire logic                  s_wvalid_i,
  output logic                       s_wready_o,
  output logic [1:0]                 s_bresp_o,
  output logic                       s_bvalid_o,
  input  wire logic                  s_bready_i,
  input  wire logic [31:0]           s_araddr_i,
  input  wire logic                  s_arvalid_i,
  output logic                       s_arready_o,
  output logic [31:0]                s_rdata_o,
  output logic [1:0]                 s_rresp_o,
  output logic                       s_rvalid_o,
  input  wire logic                  s_rready_i
);

  import kbd_code_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_PULSE = 2'b01,
    TX_BREAK = 2'b11
  } tx_state_t;

  localparam int unsigned TW = 32;

  logic [7:0]  key_pulses;
  logic [31:0] ctrl_reg, next_ctrl_reg;

  kbd_code_encoder u_enc (
    .key_i           (key_i),
    .parity_fitted_i (ctrl_reg[CTRL_PARITY_BIT]),
    .pulses_o        (key_pulses)
  );

  // ******************************************************************
  // register file and AXI4-Lite slave
  // ******************************************************************
  logic [7:0]  last_char, next_last_char;
  logic        aw_held, next_aw_held, w_held, next_w_held;
  logic [31:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;
  logic        release_pulse;
  logic [31:0] status_word;

  logic       rx_break_latch, next_rx_break_latch;
  logic       hold_latch, next_hold_latch;
  logic       hold_armed, next_hold_armed;

  tx_state_t  tx_state, next_tx_state;
  logic [7:0] shift_reg, next_shift_reg;
  logic [3:0] pulse_idx, next_pulse_idx;
  logic [TW-1:0] tx_cnt, next_tx_cnt;
  logic [TW-1:0] brk_cnt, next_brk_cnt;
  logic       send_level, next_send_level;
  logic       sel_reg, next_sel_reg;

  assign s_awready_o = !aw_held && !bvalid;
  assign s_wready_o  = !w_held && !bvalid;
  assign s_arready_o = !rvalid;
  assign s_bvalid_o  = bvalid;
  assign s_bresp_o   = bresp;
  assign s_rvalid_o  = rvalid;
  assign s_rdata_o   = rdata;
  assign s_rresp_o   = rresp;

  always_comb begin
    status_word                 = 32'h0000_0000;
    status_word[ST_BUSY_BIT]    = (tx_state != TX_IDLE);
    status_word[ST_RXBRK_BIT]   = rx_break_latch;
    status_word[ST_HOLD_BIT]    = hold_latch;
    status_word[ST_BRKSEND_BIT] = (tx_state == TX_BREAK);
  end

  always_comb begin
    next_aw_held  = aw_held;
    next_aw_addr  = aw_addr;
    next_w_held   = w_held;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_ctrl_reg = ctrl_reg;
    next_rvalid   = rvalid;
    next_rdata    = rdata;
    next_rresp    = rresp;
    release_pulse = 1'b0;
    if (s_awvalid_i && s_awready_o) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_awaddr_i;
    end
    if (s_wvalid_i && s_wready_o) begin
      next_w_held = 1'b1;
      next_w_data = s_wdata_i;
      next_w_strb = s_wstrb_i;
    end
    if (aw_held && w_held) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (aw_addr[7:0] == CTRL_OFS && aw_addr[31:8] == 24'h00_0000) begin
        if (w_strb[0]) begin
          next_ctrl_reg[1:0] = w_data[1:0];
          release_pulse      = w_data[CTRL_RELEASE_BIT];
        end
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (bvalid && s_bready_i) begin
      next_bvalid = 1'b0;
    end
    if (s_arvalid_i && s_arready_o) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      if (s_araddr_i[31:8] != 24'h00_0000) begin
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
      end else begin
        unique case (s_araddr_i[7:0])
          CTRL_OFS:   next_rdata = {30'h0000_0000, ctrl_reg[1:0]};
          STATUS_OFS: next_rdata = status_word;
          CHAR_OFS:   next_rdata = {24'h00_0000, last_char};
          default: begin
            next_rdata = 32'h0000_0000;
            next_rresp = RESP_SLVERR;
          end
        endcase
      end
    end else if (rvalid && s_rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  // ******************************************************************
  // break latches
  // ******************************************************************
  logic variant_b;
  assign variant_b = ctrl_reg[CTRL_VARIANT_BIT];

  always_comb begin
    // release clears; a break arriving the same cycle still wins
    next_rx_break_latch = rx_break_latch;
    if (release_pulse || break_release_button_i) begin
      next_rx_break_latch = 1'b0;
    end
    if (rx_break_detected_i) begin
      next_rx_break_latch = 1'b1;
    end
    next_hold_latch = hold_latch;
    next_hold_armed = hold_armed;
    // once armed the latch holds itself regardless of connect
    if (variant_b && !hold_armed && line_connected_i) begin
      next_hold_latch = 1'b1;
      next_hold_armed = 1'b1;
    end
    if (variant_b && hold_latch && break_key_i) begin
      next_hold_latch = 1'b0;
    end
    if (variant_b && tx_state == TX_BREAK && brk_cnt == TW'(1)) begin
      next_hold_latch = 1'b1;
    end
  end

  // ******************************************************************
  // distributor and break timer
  // ******************************************************************
  logic       start_char;
  src_sel_t   src;
  logic [7:0] src_pulses;
  logic       send_block;

  assign send_block   = rx_break_latch || (variant_b && !copy_enable_i);
  assign char_ready_o = (tx_state == TX_IDLE) && !send_block;

  always_comb begin
    src        = SRC_NONE;
    src_pulses = 8'h00;
    if (key_strobe_i) begin
      src        = SRC_KEY;
      src_pulses = key_pulses;
    end else if (tape_strobe_i) begin
      src        = SRC_TAPE;
      src_pulses = tape_holes_i;
    end else if (answer_strobe_i) begin
      src        = SRC_ANSWER;
      src_pulses = answer_drum_i;
    end
  end
  assign start_char = char_ready_o && (src != SRC_NONE);

  always_comb begin
    next_tx_state   = tx_state;
    next_shift_reg  = shift_reg;
    next_pulse_idx  = pulse_idx;
    next_tx_cnt     = tx_cnt;
    next_brk_cnt    = brk_cnt;
    next_last_char  = last_char;
    next_send_level = 1'b1;
    // break key held: count toward recognition in the first variant
    if (!variant_b && break_key_i && tx_state != TX_BREAK) begin
      if (brk_cnt < TW'(DETECT_CYC)) begin
        next_brk_cnt = brk_cnt + TW'(1);
      end
    end else if (tx_state != TX_BREAK) begin
      next_brk_cnt = '0;
    end
    unique case (tx_state)
      TX_IDLE: begin
        if (start_char) begin
          next_tx_state  = TX_PULSE;
          next_shift_reg = src_pulses;
          next_last_char = src_pulses;
          next_pulse_idx = 4'h0;
          next_tx_cnt    = TW'(BIT_CYC - 1);
          next_send_level = src_pulses[0];
        end
      end
      TX_PULSE: begin
        next_send_level = shift_reg[0];
        if (tx_cnt == '0) begin
          if (pulse_idx == 4'h7) begin
            next_tx_state   = TX_IDLE;
            next_send_level = 1'b1;
          end else begin
            next_shift_reg  = {1'b0, shift_reg[7:1]};
            next_pulse_idx  = pulse_idx + 4'h1;
            next_tx_cnt     = TW'(BIT_CYC - 1);
            next_send_level = shift_reg[1];
          end
        end else begin
          next_tx_cnt = tx_cnt - TW'(1);
        end
      end
      TX_BREAK: begin
        next_send_level = 1'b0;
        next_brk_cnt    = brk_cnt - TW'(1);
        if (brk_cnt == TW'(1)) begin
          next_tx_state   = TX_IDLE;
          next_send_level = 1'b1;
          next_brk_cnt    = '0;
        end
      end
    endcase
    if (tx_state != TX_BREAK) begin
      if (!variant_b && brk_cnt == TW'(DETECT_CYC - 1) && break_key_i) begin
        next_tx_state   = TX_BREAK;
        next_brk_cnt    = TW'(SPACE_A_CYC);
        next_send_level = 1'b0;
      end else if (variant_b && hold_latch && break_key_i) begin
        next_tx_state   = TX_BREAK;
        next_brk_cnt    = TW'(SPACE_B_CYC);
        next_send_level = 1'b0;
      end
    end
    // blocked sending shunts the contacts to steady mark, except a break already under way when only a receive break blocks
    if (rx_break_latch && tx_state != TX_BREAK) begin
      next_send_level = 1'b1;
    end
    if (variant_b && !copy_enable_i) begin
      next_send_level = 1'b1;
    end
  end

  // receive driver: copy off forces idle mark, output is strictly binary
  assign next_sel_reg = copy_enable_i ? rx_demod_i : 1'b1;
  assign send_line_o   = send_level;
  assign selector_on_o = sel_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_reg       <= CTRL_RESET;
      last_char      <= 8'h00;
      aw_held        <= 1'b0;
      aw_addr        <= 32'h0000_0000;
      w_held         <= 1'b0;
      w_data         <= 32'h0000_0000;
      w_strb         <= 4'h0;
      bvalid         <= 1'b0;
      bresp          <= RESP_OKAY;
      rvalid         <= 1'b0;
      rdata          <= 32'h0000_0000;
      rresp          <= RESP_OKAY;
      rx_break_latch <= 1'b0;
      hold_latch     <= 1'b0;
      hold_armed     <= 1'b0;
      tx_state       <= TX_IDLE;
      shift_reg      <= 8'h00;
      pulse_idx      <= 4'h0;
      tx_cnt         <= '0;
      brk_cnt        <= '0;
      send_level     <= 1'b1;
      sel_reg        <= 1'b1;
    end else begin
      ctrl_reg       <= next_ctrl_reg;
      last_char      <= next_last_char;
      aw_held        <= next_aw_held;
      aw_addr        <= next_aw_addr;
      w_held         <= next_w_held;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      bvalid         <= next_bvalid;
      bresp          <= next_bresp;
      rvalid         <= next_rvalid;
      rdata          <= next_rdata;
      rresp          <= next_rresp;
      rx_break_latch <= next_rx_break_latch;
      hold_latch     <= next_hold_latch;
      hold_armed     <= next_hold_armed;
      tx_state       <= next_tx_state;
      shift_reg      <= next_shift_reg;
      pulse_idx      <= next_pulse_idx;
      tx_cnt         <= next_tx_cnt;
      brk_cnt        <= next_brk_cnt;
      send_level     <= next_send_level;
      sel_reg        <= next_sel_reg;
    end
  end

endmodule // kbd_code_break_gen

// ---- src/kbd_code_pkg.sv ----
/*
  Constants, types and the register map shared by the keyboard code and
  break generator.
  Assumes a 200 MHz mclk_i and an AXI4-Lite master with 32-bit data.
*/
package kbd_code_pkg;

  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned BRK_DETECT_MS   = 140;
  localparam int unsigned BRK_SPACE_A_MS  = 225;
  localparam int unsigned BRK_SPACE_B_MS  = 200;
  localparam int unsigned BRK_DETECT_CYC  = BRK_DETECT_MS * 1000 * CLK_MHZ;
  localparam int unsigned BRK_SPACE_A_CYC = BRK_SPACE_A_MS * 1000 * CLK_MHZ;
  localparam int unsigned BRK_SPACE_B_CYC = BRK_SPACE_B_MS * 1000 * CLK_MHZ;
  localparam int unsigned PULSE_CYC       = 100000;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CHAR_OFS   = 8'h08;

  // control fields
  localparam int unsigned CTRL_PARITY_BIT  = 0;
  localparam int unsigned CTRL_VARIANT_BIT = 1;
  localparam int unsigned CTRL_RELEASE_BIT = 2;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // status fields
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_RXBRK_BIT   = 1;
  localparam int unsigned ST_HOLD_BIT    = 2;
  localparam int unsigned ST_BRKSEND_BIT = 3;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SRC_NONE   = 2'b00,
    SRC_KEY    = 2'b01,
    SRC_TAPE   = 2'b10,
    SRC_ANSWER = 2'b11
  } src_sel_t;

  typedef struct packed {
    logic [7:0] code;
    logic       shift;
    logic       ctrl;
  } key_in_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
  } axil_wr_t;

endpackage

// ---- src/kbd_code_encoder.sv ----
/*
  Keyboard encoder: turns a key code plus shift and control into the
  eight code pulses. Pure combinational.
  Assumes key code bit 0 is pulse one and key code bit 7 is ignored.
*/
`timescale 1ns/10ps
module kbd_code_encoder
  import kbd_code_pkg::*;
(
  input  wire kbd_code_pkg::key_in_t key_i,
  input  wire logic                  parity_fitted_i,
  output logic [7:0]                 pulses_o
);

  logic [6:0] base;
  logic [6:0] mod;
  logic       base_p8;

  always_comb begin
    base     = key_i.code[6:0];
    mod      = base;
    mod[4]   = base[4] ^ key_i.shift;
    if (key_i.ctrl) begin
      mod[6] = 1'b0;
    end
    base_p8  = parity_fitted_i ? ^base : 1'b1;
    pulses_o = {base_p8, mod};
    if (parity_fitted_i && (key_i.shift ^ key_i.ctrl)) begin
      pulses_o[7] = ^mod;
    end
    // both modifiers: pulse eight kept at its unmodified value
    if (key_i.shift && key_i.ctrl) begin
      pulses_o[7] = base_p8;
    end
  end

endmodule // kbd_code_encoder

// ---- tb/kbd_code_break_gen_assertions.sv ----
/*
  Port checker for the keyboard code and break generator.
  Assumes the bind below hands on the design's own count parameters.
*/
`timescale 1ns/10ps
module kbd_code_checker #(
  parameter int unsigned DETECT_CYC  = 20,
  parameter int unsigned SPACE_A_CYC = 30,
  parameter int unsigned BIT_CYC     = 4
) (
  input wire logic       mclk_i,
  input wire logic       rst_i,
  input wire logic       key_strobe_i,
  input wire logic [7:0] tape_holes_i,
  input wire logic       tape_strobe_i,
  input wire logic       char_ready_o,
  input wire logic       break_key_i,
  input wire logic       break_release_button_i,
  input wire logic       rx_break_detected_i,
  input wire logic       copy_enable_i,
  input wire logic       rx_demod_i,
  input wire logic       send_line_o,
  input wire logic       selector_on_o
);
  localparam int DET     = int'(DETECT_CYC);
  localparam int LAST    = 7 * int'(BIT_CYC) + 2;
  // two back-to-back all-space characters stay split by one mark cycle between them
  localparam int LOW_MAX = (int'(SPACE_A_CYC) > 16 * int'(BIT_CYC)) ?
                           int'(SPACE_A_CYC) : 16 * int'(BIT_CYC) + 2;
  logic blk;
  logic next_blk;
  int   low_run;
  int   next_low_run;
  int   bk_cnt;
  int   next_bk_cnt;

  // ******************************
  // helper state
  // ******************************
  always_comb begin
    next_blk     = rx_break_detected_i | (blk & ~break_release_button_i);
    next_low_run = send_line_o ? 0 : low_run + 1;
    next_bk_cnt  = !break_key_i ? 0 : (bk_cnt > DET) ? bk_cnt : bk_cnt + 1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      blk     <= 1'h0;
      low_run <= 0;
      bk_cnt  <= 0;
    end else begin
      blk     <= next_blk;
      low_run <= next_low_run;
      bk_cnt  <= next_bk_cnt;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_copy_off_mark: assert property (!copy_enable_i |=> selector_on_o)
    else $error("selector left idle mark with copy off");
  a_selector_follow: assert property (copy_enable_i |=> selector_on_o == $past(rx_demod_i))
    else $error("selector does not follow receive line");
  a_rxbrk_ready: assert property (rx_break_detected_i |=> !char_ready_o [*2])
    else $error("ready after received break");
  a_rxbrk_mark: assert property (blk && $past(blk) |-> send_line_o)
    else $error("sending while receive break latched");
  a_tape_first: assert property (char_ready_o && tape_strobe_i && !key_strobe_i && copy_enable_i
    |-> ##2 send_line_o == $past(tape_holes_i[0], 2))
    else $error("first tape pulse wrong");
  a_tape_last: assert property (char_ready_o && tape_strobe_i && !key_strobe_i && copy_enable_i
    |-> ##LAST send_line_o == $past(tape_holes_i[7], LAST))
    else $error("last tape pulse wrong");
  a_break_start: assert property (bk_cnt == DET && copy_enable_i && !blk
    |-> ##[0:4] !send_line_o)
    else $error("held break key gave no space");
  a_space_bound: assert property (low_run <= LOW_MAX)
    else $error("space on send line too long");
endmodule // kbd_code_checker

bind kbd_code_break_gen kbd_code_checker #(
  .DETECT_CYC(DETECT_CYC),
  .SPACE_A_CYC(SPACE_A_CYC),
  .BIT_CYC(BIT_CYC)
) checker_i (.mclk_i, .rst_i, .key_strobe_i, .tape_holes_i, .tape_strobe_i, .char_ready_o,
  .break_key_i, .break_release_button_i, .rx_break_detected_i, .copy_enable_i, .rx_demod_i,
  .send_line_o, .selector_on_o);

// ---- tb/modem_model.sv ----
/*
  Behavioural data set: keys tones from the send line, echoes them back
  demodulated (half duplex), reports received break on command.
  Assumes one clock shared with the bench.
*/
`timescale 1ns/10ps
module modem_model #(
  parameter int unsigned CONNECT_CYC = 4
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic send_line_i,
  input  wire logic brk_cmd_i,
  output logic      tone_mark_o,
  output logic      rx_demod_o,
  output logic      rx_break_o,
  output logic      line_connected_o
);
  logic [3:0] conn_cnt;

  // ******************************
  // modulator and receive path
  // ******************************
  assign tone_mark_o      = send_line_i;
  assign line_connected_o = (conn_cnt >= 4'(CONNECT_CYC));

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_demod_o <= 1'h1;
      rx_break_o <= 1'h0;
      conn_cnt   <= 4'h0;
    end else begin
      rx_demod_o <= tone_mark_o;
      rx_break_o <= brk_cmd_i;
      if (conn_cnt != 4'hf) conn_cnt <= conn_cnt + 4'h1;
    end
  end
endmodule // modem_model

// ---- tb/tb.sv ----
/*
  Self-checking bench for the keyboard code and break generator.
  Assumes short counts on the design and the modem model at its far side.
*/
`timescale 1ns/10ps
module tb;
  import kbd_code_pkg::*;
  localparam int unsigned DET = 20, SPA = 30, SPB = 25, BIT = 4;
  logic        mclk_i = 1'h0, rst_i = 1'h1, brk_cmd = 1'h0, sel_and;
  key_in_t     key_i = '0, k;
  logic        key_strobe_i = 1'h0, tape_strobe_i = 1'h0, answer_strobe_i = 1'h0;
  logic        break_key_i = 1'h0, break_release_button_i = 1'h0, copy_enable_i = 1'h1;
  logic [7:0]  tape_holes_i = 8'h0, answer_drum_i = 8'h0, p, th, ad;
  logic [31:0] s_awaddr_i = '0, s_wdata_i = '0, s_araddr_i = '0, s_rdata_o, rd;
  logic [3:0]  s_wstrb_i = 4'h0;
  logic        s_awvalid_i = 1'h0, s_wvalid_i = 1'h0, s_bready_i = 1'h0;
  logic        s_arvalid_i = 1'h0, s_rready_i = 1'h0;
  logic        char_ready_o, send_line_o, selector_on_o, s_awready_o, s_wready_o;
  logic        s_bvalid_o, s_arready_o, s_rvalid_o;
  logic [1:0]  s_bresp_o, s_rresp_o, rs;
  logic        rx_demod_i, rx_break_detected_i, line_connected_i;
  int          err_count = 0, total_checks = 0, lows;

  kbd_code_break_gen #(.DETECT_CYC(DET), .SPACE_A_CYC(SPA), .SPACE_B_CYC(SPB), .BIT_CYC(BIT)) dut (
    .mclk_i, .rst_i, .key_i, .key_strobe_i, .tape_holes_i, .tape_strobe_i, .answer_drum_i,
    .answer_strobe_i, .char_ready_o, .break_key_i, .break_release_button_i,
    .rx_break_detected_i, .line_connected_i, .copy_enable_i, .rx_demod_i, .send_line_o,
    .selector_on_o, .s_awaddr_i, .s_awvalid_i, .s_awready_o, .s_wdata_i, .s_wstrb_i,
    .s_wvalid_i, .s_wready_o, .s_bresp_o, .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i,
    .s_arready_o, .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i);

  modem_model modem (.mclk_i, .rst_i, .send_line_i(send_line_o), .brk_cmd_i(brk_cmd),
    .tone_mark_o(), .rx_demod_o(rx_demod_i), .rx_break_o(rx_break_detected_i),
    .line_connected_o(line_connected_i));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ******************************
  // expectations and bus tasks
  // ******************************
  function automatic logic [7:0] enc(logic [6:0] c, logic sh, logic ct, logic par);
    logic [6:0] m;
    m = c;
    if (sh) m[4] = ~m[4];
    if (ct) m[6] = 1'h0;
    // both modifiers together leave pulse eight at its plain value
    return {(!par) ? 1'h1 : (sh && ct) ? ^c : ^m, m};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_awaddr_i  <= a;
    s_wdata_i   <= d;
    s_wstrb_i   <= 4'hf;
    s_awvalid_i <= 1'h1;
    s_wvalid_i  <= 1'h1;
    s_bready_i  <= 1'h1;
    do begin
      @(posedge mclk_i);
      if (s_awvalid_i && s_awready_o) s_awvalid_i <= 1'h0;
      if (s_wvalid_i && s_wready_o) s_wvalid_i <= 1'h0;
    end while (s_bvalid_o !== 1'h1);
    r = s_bresp_o;
    s_bready_i <= 1'h0;
  endtask

  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_araddr_i  <= a;
    s_arvalid_i <= 1'h1;
    s_rready_i  <= 1'h1;
    do begin
      @(posedge mclk_i);
      if (s_arvalid_i && s_arready_o) s_arvalid_i <= 1'h0;
    end while (s_rvalid_o !== 1'h1);
    d = s_rdata_o;
    r = s_rresp_o;
    s_rready_i <= 1'h0;
  endtask

  // samples each pulse mid-way, strobes given as {answer, tape, key}
  task automatic cap(input logic [2:0] sm, output logic [7:0] q);
    @(posedge mclk_i);
    while (char_ready_o !== 1'h1) @(posedge mclk_i);
    {answer_strobe_i, tape_strobe_i, key_strobe_i} <= sm;
    @(posedge mclk_i);
    {answer_strobe_i, tape_strobe_i, key_strobe_i} <= 3'h0;
    sel_and = 1'h1;
    for (int i = 0; i < 8; i++) begin
      repeat ((i == 0) ? 2 : BIT) @(posedge mclk_i);
      q[i] = send_line_o;
      sel_and &= selector_on_o;
    end
  endtask

  task automatic brk(input int h, output int n);
    @(posedge mclk_i);
    break_key_i <= 1'h1;
    n = 0;
    for (int i = 0; i < 120; i++) begin
      @(posedge mclk_i);
      if (i == h - 1) break_key_i <= 1'h0;
      n += int'(send_line_o === 1'h0);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    $display("CHECK FAILED watchdog expected done seen hang");
    stop_test;
  end

  // ******************************
  // main sequence
  // ******************************
  initial begin
    void'($urandom(32'h17f9));
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'h0;
    @(posedge mclk_i);
    chk("idle line", 32'h1, send_line_o);
    axr(32'(CTRL_OFS), rd, rs);
    chk("ctrl reset", CTRL_RESET, rd);
    axr(32'h10, rd, rs);
    chk("unmapped read", 32'(RESP_SLVERR), 32'(rs));
    axw(32'h10, 32'h0, rs);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(rs));
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      if (i % 4 == 0) axw(32'(CTRL_OFS), {31'h0, i[2]}, rs);
      k = {(i == 0) ? 8'h0 : (i == 1) ? 8'hff : 8'($urandom), i[0], i[1]};
      key_i <= k;
      cap(3'h1, p);
      chk("key code", enc(k.code[6:0], k.shift, k.ctrl, i[2]), p);
    end
    $display("test keys done");
    th = 8'($urandom);
    ad = 8'($urandom);
    tape_holes_i <= th;
    answer_drum_i <= ad;
    cap(3'h2, p);
    chk("tape code", th, p);
    cap(3'h4, p);
    chk("answer code", ad, p);
    cap(3'h7, p);
    chk("key first", enc(k.code[6:0], k.shift, k.ctrl, 1'h1), p);
    axw(32'(CTRL_OFS), 32'h0, rs);
    tape_holes_i <= 8'h0;
    copy_enable_i <= 1'h0;
    cap(3'h2, p);
    chk("copy off send", 32'h0, p);
    chk("copy off selector", 32'h1, sel_and);
    copy_enable_i <= 1'h1;
    tape_holes_i <= 8'h80;
    cap(3'h2, p);
    chk("copy on selector", 32'h0, sel_and);
    $display("test sources done");
    brk_cmd <= 1'h1;
    @(posedge mclk_i);
    brk_cmd <= 1'h0;
    repeat (3) @(posedge mclk_i);
    chk("blocked ready", 32'h0, char_ready_o);
    axr(32'(STATUS_OFS), rd, rs);
    chk("rx break flag", 32'h1, rd[ST_RXBRK_BIT]);
    break_release_button_i <= 1'h1;
    @(posedge mclk_i);
    break_release_button_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    chk("released ready", 32'h1, char_ready_o);
    brk(DET - 2, lows);
    chk("short break", 32'h0, lows);
    brk(DET + 2, lows);
    chk("break space", SPA, lows);
    $display("test break a done");
    axw(32'(CTRL_OFS), 32'h6, rs);
    axr(32'(CTRL_OFS), rd, rs);
    chk("release reads 0", 32'h2, rd);
    axr(32'(STATUS_OFS), rd, rs);
    chk("hold armed", 32'h1, rd[ST_HOLD_BIT]);
    brk(3, lows);
    chk("b space", SPB, lows);
    axr(32'(STATUS_OFS), rd, rs);
    chk("hold rearmed", 32'h1, rd[ST_HOLD_BIT]);
    // copy off in this variant blocks characters, so a break must stay mark
    copy_enable_i <= 1'h0;
    brk(3, lows);
    chk("b copy off send", 32'h0, lows);
    $display("test break b done");
    stop_test;
  end
endmodule // tb
